/* rtl/drcr_bank.sv */
// Control and status register bank for two step-down regulators
`timescale 1ns/1ps
`include "drcr_regs.svh"
module drcr_bank #(
    parameter logic [1:0] PART_CODE = 2'h1, // Arbitrary value
    parameter logic [7:0] CONFIG_IMAGE_CODE = 8'h01 // Arbitrary value
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic en_pin_in,
    input wire logic [8:0] load_current_in,
    input wire logic [7:0] top_events_in,
    input wire logic [7:0] regulator_events_in,
    output logic int_out,
    output logic [7:0] top_status_out,
    output logic [7:0] regulator_status_out,
    output logic load_current_sel_out,
    output logic reg_a_run_out,
    output logic reg_a_discharge_on_out,
    output logic reg_a_forced_pwm_out,
    output drcr_pkg::drcr_code_t reg_a_current_limit_out,
    output drcr_pkg::drcr_code_t reg_a_slew_code_out,
    output logic reg_b_run_out,
    output logic reg_b_discharge_on_out,
    output logic reg_b_forced_pwm_out,
    output drcr_pkg::drcr_code_t reg_b_current_limit_out,
    output drcr_pkg::drcr_code_t reg_b_slew_code_out,
    output logic code_reserved_out
);
    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    drcr_pkg::drcr_byte_t reg_a_control_q, reg_a_control_d; // Regulator A control
    drcr_pkg::drcr_byte_t reg_a_limit_slew_q, reg_a_limit_slew_d; // A limit and slew
    drcr_pkg::drcr_byte_t reg_b_control_q, reg_b_control_d; // Regulator B control
    drcr_pkg::drcr_byte_t reg_b_limit_slew_q, reg_b_limit_slew_d; // B limit and slew
    drcr_pkg::drcr_byte_t top_mask_a_q, top_mask_a_d; // Top event masks
    drcr_pkg::drcr_byte_t top_mask_b_q, top_mask_b_d; // Spare mask byte
    drcr_pkg::drcr_byte_t reg_mask_q, reg_mask_d; // Regulator event masks
    drcr_pkg::drcr_byte_t select_q, select_d; // Load current source select
    drcr_pkg::drcr_byte_t top_stat_q, top_stat_d; // Sticky top events
    drcr_pkg::drcr_byte_t reg_stat_q, reg_stat_d; // Sticky regulator events
    drcr_pkg::drcr_byte_t rdata_q, rdata_d; // Registered read data
    logic reserved_a, reserved_b; // Reserved code flags per channel
    logic [2:0] pin_sync_q, pin_sync_d; // Enable pin capture chain, bit 0 first
    logic pin_level_q, pin_level_d; // Filtered enable pin level
    // Merge only writable bits, keeping reserved bits at zero
    function automatic drcr_pkg::drcr_byte_t merge(input drcr_pkg::drcr_byte_t wmask,
                                                   input drcr_pkg::drcr_byte_t value);
        merge = value & wmask;
    endfunction
    // ------------------------------------------------------------------------
    // Register write and event capture
    // ------------------------------------------------------------------------
    // Writes are full bytes; a write to a read-only offset is ignored
    always_comb begin
        reg_a_control_d = reg_a_control_q;
        reg_a_limit_slew_d = reg_a_limit_slew_q;
        reg_b_control_d = reg_b_control_q;
        reg_b_limit_slew_d = reg_b_limit_slew_q;
        top_mask_a_d = top_mask_a_q;
        top_mask_b_d = top_mask_b_q;
        reg_mask_d = reg_mask_q;
        select_d = select_q;
        if (wr_en_in) begin
            unique case (addr_in)
                `DRCR_OFS_REG_A_CONTROL: begin
                    reg_a_control_d = merge(`DRCR_CONTROL_WMASK, wdata_in);
                end
                `DRCR_OFS_REG_A_LIMIT_SLEW: begin
                    reg_a_limit_slew_d = merge(`DRCR_LIMIT_SLEW_WMASK, wdata_in);
                end
                `DRCR_OFS_REG_B_CONTROL: begin
                    reg_b_control_d = merge(`DRCR_CONTROL_WMASK, wdata_in);
                end
                `DRCR_OFS_REG_B_LIMIT_SLEW: begin
                    reg_b_limit_slew_d = merge(`DRCR_LIMIT_SLEW_WMASK, wdata_in);
                end
                `DRCR_OFS_TOP_EVENT_MASK_A: begin
                    top_mask_a_d = merge(`DRCR_TOP_A_WMASK, wdata_in);
                end
                `DRCR_OFS_TOP_EVENT_MASK_B: begin
                    top_mask_b_d = merge(`DRCR_TOP_B_WMASK, wdata_in);
                end
                `DRCR_OFS_REGULATOR_EVENT_MASK: begin
                    reg_mask_d = merge(`DRCR_REG_MASK_WMASK, wdata_in);
                end
                `DRCR_OFS_LOAD_CURRENT_SELECT: begin
                    select_d = merge(`DRCR_SELECT_WMASK, wdata_in);
                end
                default: begin
                    // Read-only or unmapped offsets: nothing changes
                end
            endcase
        end
        // Events are recorded whatever the mask; a set beats a clear
        top_stat_d = top_stat_q | top_events_in;
        reg_stat_d = reg_stat_q | regulator_events_in;
        if (wr_en_in && addr_in == `DRCR_OFS_TOP_EVENT_MASK_B) begin
            // Writing ones to the spare mask byte clears top status bits
            top_stat_d = (top_stat_q & ~wdata_in) | top_events_in;
        end
        if (wr_en_in && addr_in == `DRCR_OFS_LOAD_CURRENT_SELECT) begin
            // Writing the select byte also clears regulator status bits
            reg_stat_d = (reg_stat_q & ~wdata_in) | regulator_events_in;
        end
    end
    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Unmapped offsets read zero
    always_comb begin
        unique case (addr_in)
            `DRCR_OFS_IDENTITY_REVISION: rdata_d = {PART_CODE, `DRCR_ID_FIXED_LOW};
            `DRCR_OFS_CONFIG_IMAGE_VERSION: rdata_d = CONFIG_IMAGE_CODE;
            `DRCR_OFS_REG_A_CONTROL: rdata_d = reg_a_control_q;
            `DRCR_OFS_REG_A_LIMIT_SLEW: rdata_d = reg_a_limit_slew_q;
            `DRCR_OFS_REG_B_CONTROL: rdata_d = reg_b_control_q;
            `DRCR_OFS_REG_B_LIMIT_SLEW: rdata_d = reg_b_limit_slew_q;
            `DRCR_OFS_TOP_EVENT_MASK_A: rdata_d = top_mask_a_q;
            `DRCR_OFS_TOP_EVENT_MASK_B: rdata_d = top_mask_b_q;
            `DRCR_OFS_REGULATOR_EVENT_MASK: rdata_d = reg_mask_q;
            `DRCR_OFS_LOAD_CURRENT_SELECT: rdata_d = select_q;
            `DRCR_OFS_LOAD_CURRENT_HIGH: rdata_d = {7'h00, load_current_in[8]};
            `DRCR_OFS_LOAD_CURRENT_LOW: rdata_d = load_current_in[7:0];
            default: rdata_d = 8'h00;
        endcase
    end
    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    // Synchronous reset; discharge bit comes up set
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_a_control_q <= `DRCR_RST_CONTROL;
            reg_a_limit_slew_q <= `DRCR_RST_LIMIT_SLEW;
            reg_b_control_q <= `DRCR_RST_CONTROL;
            reg_b_limit_slew_q <= `DRCR_RST_LIMIT_SLEW;
            top_mask_a_q <= `DRCR_RST_MASK;
            top_mask_b_q <= `DRCR_RST_MASK;
            reg_mask_q <= `DRCR_RST_MASK;
            select_q <= `DRCR_RST_MASK;
            top_stat_q <= 8'h00;
            reg_stat_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            reg_a_control_q <= reg_a_control_d;
            reg_a_limit_slew_q <= reg_a_limit_slew_d;
            reg_b_control_q <= reg_b_control_d;
            reg_b_limit_slew_q <= reg_b_limit_slew_d;
            top_mask_a_q <= top_mask_a_d;
            top_mask_b_q <= top_mask_b_d;
            reg_mask_q <= reg_mask_d;
            select_q <= select_d;
            top_stat_q <= top_stat_d;
            reg_stat_q <= reg_stat_d;
            rdata_q <= rdata_d;
        end
    end
    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // A masked event stays in status but cannot raise the interrupt
    assign int_out = |(top_stat_q & ~top_mask_a_q) | |(reg_stat_q & ~reg_mask_q);
    assign rdata_out = rdata_q;
    assign top_status_out = top_stat_q;
    assign regulator_status_out = reg_stat_q;
    assign load_current_sel_out = select_q[0];
    assign code_reserved_out = reserved_a | reserved_b;
    // ------------------------------------------------------------------------
    // Enable pin synchroniser
    // ------------------------------------------------------------------------
    // The pin is asynchronous to our clock: three stages, then a change
    // counts only once stages two and three agree. Costs four cycles of
    // lag, which is nothing next to a regulator start-up.
    always_comb begin
        pin_sync_d = {pin_sync_q[1:0], en_pin_in}; // Stage one feeds only stage two
        pin_level_d = pin_level_q;
        if (pin_sync_q[1] == pin_sync_q[2]) begin
            // Both late stages agree, so the new level is accepted
            pin_level_d = pin_sync_q[2];
        end
    end
    // Pin stages come up low, like an idle pin
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin_sync_q <= 3'h0;
            pin_level_q <= 1'b0;
        end else begin
            pin_sync_q <= pin_sync_d;
            pin_level_q <= pin_level_d;
        end
    end
    // Both channels see the same filtered pin level
    drcr_channel u_chan_a (
        .control_in(reg_a_control_q),
        .limit_slew_in(reg_a_limit_slew_q),
        .pin_enable_in(pin_level_q),
        .run_out(reg_a_run_out),
        .discharge_out(reg_a_discharge_on_out),
        .forced_pwm_out(reg_a_forced_pwm_out),
        .limit_code_out(reg_a_current_limit_out),
        .slew_code_out(reg_a_slew_code_out),
        .code_reserved_out(reserved_a)
    );
    drcr_channel u_chan_b (
        .control_in(reg_b_control_q),
        .limit_slew_in(reg_b_limit_slew_q),
        .pin_enable_in(pin_level_q),
        .run_out(reg_b_run_out),
        .discharge_out(reg_b_discharge_on_out),
        .forced_pwm_out(reg_b_forced_pwm_out),
        .limit_code_out(reg_b_current_limit_out),
        .slew_code_out(reg_b_slew_code_out),
        .code_reserved_out(reserved_b)
    );
endmodule // drcr_bank

/* rtl/drcr_channel.sv */
// One regulator's control decode: run, discharge, mode, limit and slew
`timescale 1ns/1ps
`include "drcr_regs.svh"
module drcr_channel (
    input wire logic [7:0] control_in,
    input wire logic [7:0] limit_slew_in,
    input wire logic pin_enable_in,
    output logic run_out,
    output logic discharge_out,
    output logic forced_pwm_out,
    output drcr_pkg::drcr_code_t limit_code_out,
    output drcr_pkg::drcr_code_t slew_code_out,
    output logic code_reserved_out
);
    // ------------------------------------------------------------------------
    // Run decision and derived controls
    // ------------------------------------------------------------------------
    // Gating on means enable bit AND pin, else the bit alone
    always_comb begin
        run_out = control_in[`DRCR_BIT_SW_ENABLE]
            & (~control_in[`DRCR_BIT_PIN_GATING] | pin_enable_in);
        // Resistor only while the output is off
        discharge_out = control_in[`DRCR_BIT_DISCHARGE] & ~run_out;
        forced_pwm_out = control_in[`DRCR_BIT_FORCED_PWM];
        // Limit passes straight through, live at any time
        limit_code_out = limit_slew_in[`DRCR_LIMIT_MSB:`DRCR_LIMIT_LSB];
        // One slew code serves both ramp directions
        slew_code_out = limit_slew_in[`DRCR_SLEW_MSB:`DRCR_SLEW_LSB];
        code_reserved_out = (limit_code_out > `DRCR_LIMIT_MAX_CODE)
            | (slew_code_out < `DRCR_SLEW_MIN_CODE);
    end
endmodule // drcr_channel

/* rtl/drcr_pkg.sv */
// Types shared by the regulator control bank
package drcr_pkg;
    typedef logic [7:0] drcr_byte_t; // One register byte
    typedef logic [2:0] drcr_code_t; // Limit or slew code
endpackage

/* rtl/drcr_regs.svh */
// Register offsets, field positions, reset values, write masks and code limits of the regulator control bank
`ifndef DRCR_REGS_SVH
`define DRCR_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DRCR_OFS_IDENTITY_REVISION 8'h00
`define DRCR_OFS_CONFIG_IMAGE_VERSION 8'h01
`define DRCR_OFS_REG_A_CONTROL 8'h02
`define DRCR_OFS_REG_A_LIMIT_SLEW 8'h03
`define DRCR_OFS_REG_B_CONTROL 8'h04
`define DRCR_OFS_REG_B_LIMIT_SLEW 8'h05
`define DRCR_OFS_TOP_EVENT_MASK_A 8'h20
`define DRCR_OFS_TOP_EVENT_MASK_B 8'h21
`define DRCR_OFS_REGULATOR_EVENT_MASK 8'h22
`define DRCR_OFS_LOAD_CURRENT_SELECT 8'h24
`define DRCR_OFS_LOAD_CURRENT_HIGH 8'h25
`define DRCR_OFS_LOAD_CURRENT_LOW 8'h26
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DRCR_BIT_SW_ENABLE 0
`define DRCR_BIT_PIN_GATING 1
`define DRCR_BIT_DISCHARGE 2
`define DRCR_BIT_FORCED_PWM 3
`define DRCR_LIMIT_MSB 5
`define DRCR_LIMIT_LSB 3
`define DRCR_SLEW_MSB 2
`define DRCR_SLEW_LSB 0
`define DRCR_ID_MSB 7
`define DRCR_ID_LSB 6
// ----------------------------------------------------------------------------
// Reset and fixed values, write masks and code limits
// ----------------------------------------------------------------------------
`define DRCR_RST_CONTROL 8'h04
`define DRCR_RST_LIMIT_SLEW 8'h02
`define DRCR_RST_MASK 8'h00
`define DRCR_ID_FIXED_LOW 6'h02
`define DRCR_CONTROL_WMASK 8'h0f
`define DRCR_LIMIT_SLEW_WMASK 8'h3f
`define DRCR_TOP_A_WMASK 8'h95
`define DRCR_TOP_B_WMASK 8'h00
`define DRCR_REG_MASK_WMASK 8'hdd
`define DRCR_SELECT_WMASK 8'h01
`define DRCR_LIMIT_MAX_CODE 3'h5
`define DRCR_SLEW_MIN_CODE 3'h2
`endif

/* tb/drcr_bank_monitor.sv */
// Concurrent checks on the regulator control bank ports
`timescale 1ns/1ps
module drcr_bank_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic en_pin_in,
    input wire logic [8:0] load_current_in,
    input wire logic [7:0] regulator_events_in,
    input wire logic int_out,
    input wire logic [7:0] top_status_out,
    input wire logic [7:0] regulator_status_out,
    input wire logic reg_a_run_out,
    input wire logic reg_a_discharge_on_out,
    input wire logic reg_a_forced_pwm_out,
    input wire drcr_pkg::drcr_code_t reg_a_current_limit_out,
    input wire drcr_pkg::drcr_code_t reg_b_slew_code_out
);
    // ------------------------------------------------------------------
    // Single clock domain, checks paused in reset
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Write step to the channel A control byte used below
    sequence s_wr_a_ctl;
        wr_en_in && addr_in == 8'h02;
    endsequence
    // Edges since the enable pin last moved, saturating at seven
    logic [2:0] pin_quiet_q;
    logic pin_prev_q; // Pin level at the previous edge
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin_quiet_q <= 3'h0;
            pin_prev_q <= 1'b0;
        end else begin
            if (en_pin_in != pin_prev_q) begin
                pin_quiet_q <= 3'h0;
            end else if (pin_quiet_q != 3'h7) begin
                pin_quiet_q <= pin_quiet_q + 3'h1;
            end
            pin_prev_q <= en_pin_in;
        end
    end
    // Control write with the pin steady long enough to pass the block's filter
    sequence s_wr_a_ctl_settled;
        wr_en_in && addr_in == 8'h02 && pin_quiet_q == 3'h7 && en_pin_in == pin_prev_q;
    endsequence
    sequence s_wr_a_ls;
        wr_en_in && addr_in == 8'h03;
    endsequence
    sequence s_wr_b_ls;
        wr_en_in && addr_in == 8'h05;
    endsequence
    // Pin is filtered in the block, so run is judged only on a steady pin
    a_run_gating: assert property (s_wr_a_ctl_settled |=> reg_a_run_out ==
        ($past(wdata_in[0]) && (!$past(wdata_in[1]) || $past(en_pin_in))))
        else $error("run mismatch");
    a_mode_forced: assert property (s_wr_a_ctl |=> reg_a_forced_pwm_out ==
        $past(wdata_in[3])) else $error("mode bit mismatch");
    a_discharge_off: assert property (s_wr_a_ctl |=> reg_a_discharge_on_out ==
        ($past(wdata_in[2]) && !reg_a_run_out)) else $error("discharge mismatch");
    a_discharge_reset: assert property ($rose(rst_n_in) |->
        reg_a_discharge_on_out && !reg_a_run_out) else $error("discharge not set by reset");
    a_limit_apply: assert property (s_wr_a_ls |=> reg_a_current_limit_out ==
        $past(wdata_in[5:3])) else $error("limit code not applied");
    a_slew_apply: assert property (s_wr_b_ls |=> reg_b_slew_code_out ==
        $past(wdata_in[2:0])) else $error("slew code not applied");
    a_id_pattern: assert property (addr_in == 8'h00 |=> rdata_out[5:0] == 6'h02)
        else $error("identity low bits wrong");
    a_load_split: assert property (addr_in == 8'h26 |=>
        rdata_out == $past(load_current_in[7:0])) else $error("load low byte wrong");
    a_status_kept: assert property (regulator_events_in[0] |=> regulator_status_out[0])
        else $error("event not recorded");
    a_int_quiet: assert property (top_status_out == 8'h00 && regulator_status_out == 8'h00
        |-> !int_out) else $error("interrupt without status");
endmodule // drcr_bank_monitor
bind drcr_bank drcr_bank_monitor drcr_bank_monitor_inst (.ref_clk_in, .rst_n_in, .wr_en_in,
    .addr_in, .wdata_in, .rdata_out, .en_pin_in, .load_current_in, .regulator_events_in,
    .int_out, .top_status_out, .regulator_status_out, .reg_a_run_out, .reg_a_discharge_on_out,
    .reg_a_forced_pwm_out, .reg_a_current_limit_out, .reg_b_slew_code_out);

/* tb/drcr_host_model.sv */
// Host-side register access model for the regulator control bank
`timescale 1ns/1ps
module drcr_host_model (
    input wire logic ref_clk_in,
    input wire logic [7:0] rdata_in,
    output logic wr_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    // Idle bus at time zero
    initial begin
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // Strobe for one edge, then a quiet edge so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = d;
        wr_en_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        wr_en_out = 1'b0;
        wdata_out = ~d; // Released data must not look valid
        @(posedge ref_clk_in);
        #1;
    endtask
    // Read data is registered, so take it one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_out = a;
        @(posedge ref_clk_in);
        #1;
        d = rdata_in;
    endtask
endmodule // drcr_host_model

/* tb/tb_dual_regulator_control_regs.sv */
// Self-checking bench for the regulator control bank
`timescale 1ns/1ps
module tb_dual_regulator_control_regs;
    logic ref_clk_in, rst_n_in, wr_en_in, en_pin_in, int_out, load_current_sel_out;
    logic [7:0] addr_in, wdata_in, rdata_out, top_events_in, regulator_events_in;
    logic [7:0] top_status_out, regulator_status_out, v, d;
    logic [8:0] load_current_in;
    logic reg_a_run_out, reg_a_discharge_on_out, reg_a_forced_pwm_out, code_reserved_out;
    logic reg_b_run_out, reg_b_discharge_on_out, reg_b_forced_pwm_out, r;
    drcr_pkg::drcr_code_t reg_a_current_limit_out, reg_a_slew_code_out;
    drcr_pkg::drcr_code_t reg_b_current_limit_out, reg_b_slew_code_out;
    int fail_count = 0;
    int checks_done = 0;
    // Expected reset and fixed read values, part codes chosen arbitrarily
    logic [7:0] ex_addr [11] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h20, 8'h21, 8'h22, 8'h24,
        8'h00, 8'h01, 8'h30};
    logic [7:0] ex_val [11] = '{8'h04, 8'h02, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h82, 8'h5a, 8'h00};
    drcr_bank #(.PART_CODE(2'h2), .CONFIG_IMAGE_CODE(8'h5a)) drcr_bank_inst (.*);
    drcr_host_model drcr_host_model_inst (.ref_clk_in(ref_clk_in), .rdata_in(rdata_out),
        .wr_en_out(wr_en_in), .addr_out(addr_in), .wdata_out(wdata_in));
    // ------------------------------------------------------------------
    // Clock, compare and closing
    // ------------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        en_pin_in = 1'b0;
        load_current_in = 9'h000;
        top_events_in = 8'h00;
        regulator_events_in = 8'h00;
        repeat (6) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        // Read-only and unmapped writes must leave the table untouched
        drcr_host_model_inst.wr(8'h00, 8'hff);
        drcr_host_model_inst.wr(8'h01, 8'hff);
        drcr_host_model_inst.wr(8'h30, 8'hff);
        for (int i = 0; i < 11; i++) begin
            drcr_host_model_inst.rd(ex_addr[i], d);
            chk("reset or fixed byte", {1'b0, ex_val[i]}, {1'b0, d});
        end
        // Every enable, gating, discharge, mode and pin combination on both channels
        for (int i = 0; i < 32; i++) begin
            v = {4'hf, i[3:0]};
            en_pin_in = i[4];
            drcr_host_model_inst.wr(8'h02, v);
            drcr_host_model_inst.wr(8'h04, v);
            r = v[0] & (~v[1] | i[4]);
            chk("run a", {8'h00, r}, {8'h00, reg_a_run_out});
            chk("run b", {8'h00, r}, {8'h00, reg_b_run_out});
            chk("discharge b", {8'h00, v[2] & ~r}, {8'h00, reg_b_discharge_on_out});
            chk("mode a", {8'h00, v[3]}, {8'h00, reg_a_forced_pwm_out});
            chk("discharge a", {8'h00, v[2] & ~r}, {8'h00, reg_a_discharge_on_out});
            chk("mode b", {8'h00, v[3]}, {8'h00, reg_b_forced_pwm_out});
            drcr_host_model_inst.rd(8'h04, d);
            chk("control b", {1'b0, v & 8'h0f}, {1'b0, d});
        end
        // All limit and slew codes while both channels run
        for (int i = 0; i < 8; i++) begin
            v = {2'b11, i[2:0], 3'h7 - i[2:0]};
            drcr_host_model_inst.wr(8'h03, v);
            drcr_host_model_inst.wr(8'h05, v);
            chk("still running", 9'h001, {8'h00, reg_a_run_out});
            chk("limit a", {6'h00, i[2:0]}, {6'h00, reg_a_current_limit_out});
            chk("slew b", {6'h00, 3'h7 - i[2:0]}, {6'h00, reg_b_slew_code_out});
            chk("limit b", {6'h00, i[2:0]}, {6'h00, reg_b_current_limit_out});
            chk("slew a", {6'h00, 3'h7 - i[2:0]}, {6'h00, reg_a_slew_code_out});
            chk("reserved flag", {8'h00, i > 5}, {8'h00, code_reserved_out});
            drcr_host_model_inst.rd(8'h05, d);
            chk("limit slew b", {1'b0, v & 8'h3f}, {1'b0, d});
        end
        // Nine-bit load current across two bytes
        load_current_in = 9'h1a5;
        drcr_host_model_inst.rd(8'h25, d);
        chk("load high", 9'h001, {1'b0, d});
        drcr_host_model_inst.rd(8'h26, d);
        chk("load low", 9'h0a5, {1'b0, d});
        // Masked event is recorded but silent; unmasked one raises the line
        drcr_host_model_inst.wr(8'h22, 8'h01);
        regulator_events_in = 8'h01;
        @(posedge ref_clk_in);
        #1 regulator_events_in = 8'h00;
        chk("masked status", 9'h001, {1'b0, regulator_status_out});
        chk("masked int", 9'h000, {8'h00, int_out});
        top_events_in = 8'h01;
        @(posedge ref_clk_in);
        #1 top_events_in = 8'h00;
        chk("unmasked int", 9'h001, {8'h00, int_out});
        drcr_host_model_inst.wr(8'h21, 8'h01);
        drcr_host_model_inst.wr(8'h24, 8'h01);
        chk("cleared", 9'h000, {1'b0, top_status_out | regulator_status_out});
        chk("select", 9'h001, {8'h00, load_current_sel_out});
        close_out();
    end
endmodule // tb_dual_regulator_control_regs
